// [bcfe_consts.svh]
`ifndef BCFE_CONSTS_SVH
`define BCFE_CONSTS_SVH
// ==========================================================
// Frame layout, byte positions within a nine-byte frame.
`define BCFE_POS_ADDR 4'h0
`define BCFE_POS_CMD 4'h1
`define BCFE_POS_TYPE 4'h2
`define BCFE_POS_BANK 4'h3
`define BCFE_POS_VAL3 4'h4
`define BCFE_POS_VAL0 4'h7
`define BCFE_POS_CSUM 4'h8
// Last position of a core-only frame, which starts at position 1.
`define BCFE_POS_CORE_END 4'h7
// ==========================================================
// Reply positions and status codes.
`define BCFE_RPOS_RADDR 4'h0
`define BCFE_RPOS_MADDR 4'h1
`define BCFE_RPOS_STAT 4'h2
`define BCFE_RPOS_CMD 4'h3
`define BCFE_RPOS_VAL3 4'h4
`define BCFE_ST_OK 8'h64
`define BCFE_ST_STORED 8'h65
`define BCFE_ST_BAD_SUM 8'h01
`define BCFE_ST_BAD_CMD 8'h02
`define BCFE_ST_BAD_TYPE 8'h03
`define BCFE_ST_BAD_VALUE 8'h04
`define BCFE_ST_LOCKED 8'h05
`define BCFE_ST_NOT_AVAIL 8'h06
// ==========================================================
// Timing: clock rate and the idle time that drops a partial frame.
`define BCFE_CLK_MHZ 20
`define BCFE_IDLE_TO_US 10000
`define BCFE_IDLE_TO_CYC (`BCFE_IDLE_TO_US * `BCFE_CLK_MHZ)
`define BCFE_FIFO_DEPTH 4
`endif

// [bcfe_engine.sv]
`timescale 1ns/1ps
`include "bcfe_consts.svh"
// Overview of operation
// - One reply per command, after processing completes.
// - Never transmit except when replying.
// - Release link outside reply; stay receiving.
// - Core: command, type, bank, value MSB first.
// - Serial frame: address, core, checksum; nine bytes.
// - Checksum is 8-bit sum of eight bytes.
// - CAN frame carries core only.
// - Serial reply order: raddr, maddr, status, cmd, value, sum.
// - Reply checksum is 8-bit sum of others.
// - CAN reply drops raddr and checksum bytes; maddr is kept.
// - Status 100 means executed without error.
// - Status 101 means stored into program memory.
// - Error codes one to six reported.
module bcfe_engine #(
  parameter int IDLE_TO_CYC = `BCFE_IDLE_TO_CYC,
  parameter int FIFO_DEPTH = `BCFE_FIFO_DEPTH
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic can_mode_i,
  input wire logic [7:0] module_addr_i,
  input wire logic [7:0] reply_addr_i,
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  output logic exec_req_o,
  output bcfe_pkg::bcfe_cmd_t cmd_o,
  input wire logic exec_done_i,
  input wire bcfe_pkg::bcfe_rsp_t rsp_i,
  output logic tx_valid_o,
  output logic [7:0] tx_data_o,
  input wire logic tx_ready_i,
  output logic tx_oe_n_o
);
  import bcfe_pkg::*;

  localparam int TW = $clog2(IDLE_TO_CYC + 1);
  bcfe_state_t state_q;
  bcfe_state_t state_d;
  logic [7:0] rxb_q [9];
  logic [3:0] cnt_q;
  logic [3:0] rpos;
  logic [7:0] rsum_q;
  logic [TW-1:0] idle_q;
  logic last_rx;
  logic take;
  logic addr_ok;
  logic sum_ok;
  logic frame_end;
  bcfe_rsp_t rsp_q;
  logic [3:0] tidx_q;
  logic [3:0] tpos;
  logic [7:0] tsum_q;
  logic [7:0] tbyte;
  logic last_tx;
  logic push;
  logic fifo_ready;
  logic fifo_valid;
  logic [7:0] fifo_data;
  logic fifo_pop;
  logic tx_valid_q;
  logic [7:0] tx_data_q;
  logic tx_oe_n_q;
  logic exec_req_q;
  bcfe_cmd_t cmd_q;

  // ==========================================================
  // Receive side.
  // Bytes are taken only while waiting for a command; a core-only
  // frame is stored one position up so both links share one layout.
  assign take = rx_valid_i && (state_q == BCFE_S_RX);
  assign rpos = can_mode_i ? cnt_q + 4'h1 : cnt_q;
  assign last_rx = can_mode_i ? (rpos == `BCFE_POS_CORE_END) : (rpos == `BCFE_POS_CSUM);
  assign frame_end = take && last_rx;
  assign addr_ok = can_mode_i || (rxb_q[`BCFE_POS_ADDR] == module_addr_i);
  assign sum_ok = can_mode_i || (rsum_q == rx_data_i);

  // Frame bytes land in flip-flops addressed by position.
  always_ff @(posedge clock_i) begin
    if (take) begin
      rxb_q[rpos] <= rx_data_i;
    end
  end

  // Byte counter, running sum and idle timer.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q <= 4'h0;
      rsum_q <= 8'h00;
      idle_q <= '0;
    end else if (take) begin
      idle_q <= '0;
      if (last_rx) begin
        cnt_q <= 4'h0;
        rsum_q <= 8'h00;
      end else begin
        cnt_q <= cnt_q + 4'h1;
        rsum_q <= rsum_q + rx_data_i;
      end
    end else if (cnt_q != 4'h0 && state_q == BCFE_S_RX) begin
      if (idle_q == TW'(IDLE_TO_CYC - 1)) begin
        cnt_q <= 4'h0;
        rsum_q <= 8'h00;
        idle_q <= '0;
      end else begin
        idle_q <= idle_q + 1'b1;
      end
    end else begin
      idle_q <= '0;
    end
  end

  // ==========================================================
  // Sequencing.
  // A frame for this module with a bad sum skips execution and is
  // answered at once; a frame for another module is dropped.
  always_comb begin
    state_d = state_q;
    case (state_q)
      BCFE_S_RX: begin
        if (frame_end && addr_ok) begin
          state_d = sum_ok ? BCFE_S_EXEC : BCFE_S_REPLY;
        end
      end
      BCFE_S_EXEC: begin
        if (exec_done_i) begin
          state_d = BCFE_S_REPLY;
        end
      end
      BCFE_S_REPLY: begin
        if (push && last_tx) begin
          state_d = BCFE_S_DRAIN;
        end
      end
      BCFE_S_DRAIN: begin
        if (!fifo_valid && (!tx_valid_q || tx_ready_i)) begin
          state_d = BCFE_S_RX;
        end
      end
      default: begin
        state_d = BCFE_S_RX;
      end
    endcase
  end

  // State register.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= BCFE_S_RX;
    end else begin
      state_q <= state_d;
    end
  end

  // Command hand-off to the back end; one request per good frame.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      exec_req_q <= 1'b0;
      cmd_q <= '0;
    end else begin
      exec_req_q <= frame_end && addr_ok && sum_ok;
      if (frame_end) begin
        cmd_q.cmd <= rxb_q[`BCFE_POS_CMD];
        cmd_q.typ <= rxb_q[`BCFE_POS_TYPE];
        cmd_q.bank <= rxb_q[`BCFE_POS_BANK];
        cmd_q.value <= {rxb_q[4], rxb_q[5], rxb_q[6], can_mode_i ? rx_data_i : rxb_q[`BCFE_POS_VAL0]};
      end
    end
  end

  // Result capture; the back end supplies 100, 101 or 2 to 6.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      rsp_q <= '0;
    end else if (state_q == BCFE_S_RX && frame_end && addr_ok && !sum_ok) begin
      rsp_q.status <= `BCFE_ST_BAD_SUM;
      rsp_q.value <= 32'h0000_0000;
    end else if (state_q == BCFE_S_EXEC && exec_done_i) begin
      rsp_q <= rsp_i;
    end
  end

  // ==========================================================
  // Reply builder.
  // A core-only reply starts at the module address position.
  assign tpos = can_mode_i ? tidx_q + 4'h1 : tidx_q;
  assign last_tx = can_mode_i ? (tpos == `BCFE_POS_CORE_END) : (tpos == `BCFE_POS_CSUM);
  assign push = (state_q == BCFE_S_REPLY) && fifo_ready;

  always_comb begin
    case (tpos)
      `BCFE_RPOS_RADDR: tbyte = reply_addr_i;
      `BCFE_RPOS_MADDR: tbyte = module_addr_i;
      `BCFE_RPOS_STAT: tbyte = rsp_q.status;
      `BCFE_RPOS_CMD: tbyte = rxb_q[`BCFE_POS_CMD];
      4'h4: tbyte = rsp_q.value[31:24];
      4'h5: tbyte = rsp_q.value[23:16];
      4'h6: tbyte = rsp_q.value[15:8];
      4'h7: tbyte = rsp_q.value[7:0];
      default: tbyte = tsum_q;
    endcase
  end

  // Reply index and running checksum.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      tidx_q <= 4'h0;
      tsum_q <= 8'h00;
    end else if (push) begin
      tidx_q <= last_tx ? 4'h0 : tidx_q + 4'h1;
      tsum_q <= last_tx ? 8'h00 : tsum_q + tbyte;
    end
  end

  // ==========================================================
  // Transmit path: FIFO, then an output register.
  bcfe_fifo #(
    .W(8),
    .D(FIFO_DEPTH)
  ) u_fifo (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .in_valid_i(push),
    .in_data_i(tbyte),
    .in_ready_o(fifo_ready),
    .out_valid_o(fifo_valid),
    .out_data_o(fifo_data),
    .out_ready_i(fifo_pop)
  );

  assign fifo_pop = !tx_valid_q || tx_ready_i;

  // Output register refills whenever it is empty or being taken.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      tx_valid_q <= 1'b0;
      tx_data_q <= 8'h00;
    end else if (fifo_pop) begin
      tx_valid_q <= fifo_valid;
      tx_data_q <= fifo_data;
    end
  end

  // Driver enable, low only while a reply is being built or sent.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      tx_oe_n_q <= 1'b1;
    end else begin
      tx_oe_n_q <= (state_d == BCFE_S_RX) || (state_d == BCFE_S_EXEC);
    end
  end

  assign tx_valid_o = tx_valid_q;
  assign tx_data_o = tx_data_q;
  assign tx_oe_n_o = tx_oe_n_q;
  assign exec_req_o = exec_req_q;
  assign cmd_o = cmd_q;

  // ==========================================================
  // Checks.
  a_reply_len: assert property (@(posedge clock_i) disable iff (rst_i)
    (state_q == BCFE_S_REPLY && state_d == BCFE_S_DRAIN) |-> (tpos == (can_mode_i ? 4'h7 : 4'h8)))
    else $error("Reply ended at wrong byte position.");
  a_exec_wait: assert property (@(posedge clock_i) disable iff (rst_i)
    (state_q == BCFE_S_EXEC && !exec_done_i) |=> (!push && !fifo_valid && tx_oe_n_o))
    else $error("Reply started before processing finished.");
  // A good frame raises exactly one single-cycle request.
  a_req_pulse: assert property (@(posedge clock_i) disable iff (rst_i)
    exec_req_o |=> !exec_req_o)
    else $error("Execution request longer than one cycle.");
  // The driver is enabled at the edge that sees processing finish.
  a_oe_reply: assert property (@(posedge clock_i) disable iff (rst_i)
    (state_q == BCFE_S_EXEC && exec_done_i) |=> !tx_oe_n_o)
    else $error("Driver not enabled for the reply.");
  a_silent_idle: assert property (@(posedge clock_i) disable iff (rst_i)
    (state_q == BCFE_S_RX) |-> (!push && !fifo_valid))
    else $error("Transmit activity while receiving.");
  a_bus_release: assert property (@(posedge clock_i) disable iff (rst_i)
    (state_q == BCFE_S_RX) |-> (tx_oe_n_o && !tx_valid_o))
    else $error("Link driven outside a reply.");
  a_cmd_fields: assert property (@(posedge clock_i) disable iff (rst_i)
    exec_req_o |-> (cmd_o.cmd == rxb_q[1] && cmd_o.value[31:8] == {rxb_q[4], rxb_q[5], rxb_q[6]}))
    else $error("Command fields misassembled.");
  a_bad_sum: assert property (@(posedge clock_i) disable iff (rst_i)
    (frame_end && addr_ok && !sum_ok) |=> (state_q == BCFE_S_REPLY && rsp_q.status == 8'h01 && !exec_req_o))
    else $error("Bad checksum not answered with status 1.");
  a_addr_filter: assert property (@(posedge clock_i) disable iff (rst_i)
    (frame_end && !addr_ok) |=> (state_q == BCFE_S_RX && !exec_req_o) [*2])
    else $error("Foreign frame was processed.");
  a_reply_sum: assert property (@(posedge clock_i) disable iff (rst_i)
    (push && !can_mode_i && tpos == 4'h8) |->
    (tbyte == 8'(reply_addr_i + module_addr_i + rsp_q.status + rxb_q[`BCFE_POS_CMD] +
      rsp_q.value[31:24] + rsp_q.value[23:16] + rsp_q.value[15:8] + rsp_q.value[7:0])))
    else $error("Reply checksum byte wrong.");
  a_idle_drop: assert property (@(posedge clock_i) disable iff (rst_i)
    (state_q == BCFE_S_RX && !take && cnt_q != 4'h0 && idle_q == TW'(IDLE_TO_CYC - 1)) |=> (cnt_q == 4'h0))
    else $error("Partial frame survived idle timeout.");
  a_reply_done: assert property (@(posedge clock_i) disable iff (rst_i)
    (state_q == BCFE_S_EXEC && exec_done_i) |=> (state_q == BCFE_S_REPLY) ##[1:40] (state_q == BCFE_S_DRAIN))
    else $error("Reply not built after processing.");

  c_exec: cover property (@(posedge clock_i) disable iff (rst_i) exec_req_o ##[1:50] tx_valid_o);
  c_bad_sum: cover property (@(posedge clock_i) disable iff (rst_i) frame_end && addr_ok && !sum_ok);
  c_can: cover property (@(posedge clock_i) disable iff (rst_i) frame_end && can_mode_i);
  c_stall: cover property (@(posedge clock_i) disable iff (rst_i) push ##1 !fifo_ready);
endmodule

// [bcfe_fifo.sv]
`timescale 1ns/1ps
module bcfe_fifo #(
  parameter int W = 8,
  parameter int D = 4
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  input wire logic [W-1:0] in_data_i,
  output logic in_ready_o,
  output logic out_valid_o,
  output logic [W-1:0] out_data_o,
  input wire logic out_ready_i
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  logic [W-1:0] mem_q [D];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  // Full and empty come straight from the occupancy count.
  assign in_ready_o = (cnt_q != (AW+1)'(D));
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o = mem_q[rd_q];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // Storage is written at the write index only.
  always_ff @(posedge clock_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end

  // Pointers wrap at the depth, which need not be a power of two.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(D - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(D - 1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// [bcfe_host.sv]
`timescale 1ns/1ps
module bcfe_host (
  input wire logic clock_i,
  output logic rx_valid_o,
  output logic [7:0] rx_data_o,
  input wire logic tx_valid_i,
  input wire logic [7:0] tx_data_i,
  output logic tx_ready_o
);
  logic [7:0] got_q[$];
  logic stall = 1'b0;
  // ==========================================
  // Host side of the link, idle at time zero.
  initial begin
    rx_valid_o = 1'b0;
    rx_data_o = 8'h00;
  end
  // Sends bytes back to back, then leaves the inverted last byte on the idle line.
  task automatic send(input logic [7:0] b[$]);
    foreach (b[i]) begin
      @(posedge clock_i);
      rx_valid_o <= 1'b1;
      rx_data_o <= b[i];
    end
    @(posedge clock_i);
    rx_valid_o <= 1'b0;
    rx_data_o <= ~rx_data_o;
  endtask
  // Collects reply bytes where the handshake completes; stall holds ready low.
  always @(posedge clock_i) begin
    if (tx_valid_i === 1'b1 && tx_ready_o === 1'b1) begin
      got_q.push_back(tx_data_i);
    end
    tx_ready_o <= ~stall;
  end
endmodule

// [bcfe_pkg.sv]
package bcfe_pkg;
  // ==========================================================
  // Decoded command handed to the execution back end.
  typedef struct packed {
    logic [7:0] cmd;
    logic [7:0] typ;
    logic [7:0] bank;
    logic [31:0] value;
  } bcfe_cmd_t;
  // Result returned by the execution back end.
  typedef struct packed {
    logic [7:0] status;
    logic [31:0] value;
  } bcfe_rsp_t;
  // Engine states, one-hot.
  typedef enum logic [3:0] {
    BCFE_S_RX = 4'h1,
    BCFE_S_EXEC = 4'h2,
    BCFE_S_REPLY = 4'h4,
    BCFE_S_DRAIN = 4'h8
  } bcfe_state_t;
endpackage

// [binary_command_frame_engine_bench.sv]
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin errors++; $display("mismatch at %0t: %h vs %h", $time, a, b); end end
module binary_command_frame_engine_bench;
  import bcfe_pkg::*;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic can_mode_i = 1'b0;
  logic exec_done_i = 1'b0;
  logic exec_req_o, tx_valid_o, tx_ready_i, tx_oe_n_o, rx_valid_i;
  logic [7:0] rx_data_i, tx_data_o;
  bcfe_cmd_t cmd_o, seen;
  bcfe_rsp_t rsp_i = '0;
  int errors = 0;
  int checks = 0;
  int n_req = 0;
  int dly = -1;
  logic [7:0] fr[$], ex[$];
  localparam logic [7:0] MA = 8'h05;
  localparam logic [7:0] RA = 8'h02;
  // ==========================================
  // Clock, device and host.
  always #25 clock_i = ~clock_i;
  bcfe_engine #(.IDLE_TO_CYC(20), .FIFO_DEPTH(4)) dut (.clock_i(clock_i), .rst_i(rst_i), .can_mode_i(can_mode_i),
    .module_addr_i(MA), .reply_addr_i(RA), .rx_valid_i(rx_valid_i), .rx_data_i(rx_data_i), .exec_req_o(exec_req_o),
    .cmd_o(cmd_o), .exec_done_i(exec_done_i), .rsp_i(rsp_i), .tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o),
    .tx_ready_i(tx_ready_i), .tx_oe_n_o(tx_oe_n_o));
  bcfe_host host (.clock_i(clock_i), .rx_valid_o(rx_valid_i), .rx_data_o(rx_data_i), .tx_valid_i(tx_valid_o),
    .tx_data_i(tx_data_o), .tx_ready_o(tx_ready_i));
  // Back end: latches each command and reports done four cycles later.
  always @(posedge clock_i) begin
    exec_done_i <= 1'b0;
    if (exec_req_o === 1'b1) begin
      seen <= cmd_o;
      n_req <= n_req + 1;
      dly <= 3;
    end else if (dly > 0) begin
      dly <= dly - 1;
    end else if (dly == 0) begin
      exec_done_i <= 1'b1;
      dly <= -1;
    end
  end
  // A reply byte is only offered while the driver is enabled.
  always @(negedge clock_i) begin
    if (tx_valid_o === 1'b1) `CHK(tx_oe_n_o, 1'b0)
  end
  // ==========================================
  // Helpers.
  task automatic mk(input logic [7:0] a, c, t, b, input logic [31:0] v, input logic bad);
    logic [7:0] s;
    s = 8'h00;
    fr = {c, t, b, v[31:24], v[23:16], v[15:8], v[7:0]};
    if (can_mode_i === 1'b0) begin
      fr.push_front(a);
      foreach (fr[i]) s += fr[i];
      fr.push_back(s + {7'h00, bad});
    end
  endtask
  task automatic xact(input int nexec, input logic [7:0] st, input logic [31:0] v, input int stall);
    int n0;
    int k;
    logic [7:0] s;
    n0 = n_req;
    k = can_mode_i ? 0 : 1;
    s = 8'h00;
    host.got_q.delete();
    ex.delete();
    if (st != 8'h00) begin
      ex = {MA, st, fr[k], v[31:24], v[23:16], v[15:8], v[7:0]};
      if (can_mode_i === 1'b0) begin
        ex.push_front(RA);
        foreach (ex[i]) s += ex[i];
        ex.push_back(s);
      end
    end
    host.stall <= (stall > 0);
    host.send(fr);
    repeat (stall) @(posedge clock_i);
    if (stall > 0) begin
      `CHK(tx_valid_o, 1'b1)
      `CHK(host.got_q.size(), 0)
      host.stall <= 1'b0;
    end
    for (int i = 0; i < 300 && host.got_q.size() < ex.size(); i++) @(posedge clock_i);
    repeat (40) @(posedge clock_i);
    `CHK(n_req - n0, nexec)
    `CHK(host.got_q.size(), ex.size())
    foreach (ex[i]) if (i < host.got_q.size()) `CHK(host.got_q[i], ex[i])
    `CHK(tx_oe_n_o, 1'b1)
    if (nexec > 0) `CHK(seen, {fr[k], fr[k+1], fr[k+2], fr[k+3], fr[k+4], fr[k+5], fr[k+6]})
  endtask
  // ==========================================
  // Scenarios.
  task automatic t_ok();
    rsp_i <= '{8'h64, 32'h89abcdef};
    mk(MA, 8'h06, 8'h04, 8'h00, 32'h123456f8, 1'b0);
    xact(1, 8'h64, 32'h89abcdef, 0);
    $display("t_ok done");
  endtask
  task automatic t_codes();
    logic [7:0] sts[6] = '{8'h65, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06};
    foreach (sts[i]) begin
      rsp_i <= '{sts[i], {24'h00a5c3, sts[i]}};
      mk(MA, 8'h80 + 8'(i), 8'hff, 8'h01, 32'hfedc0000 + i, 1'b0);
      xact(1, sts[i], {24'h00a5c3, sts[i]}, 0);
    end
    $display("t_codes done");
  endtask
  task automatic t_stall();
    rsp_i <= '{8'h64, 32'hffff0001};
    mk(MA, 8'h05, 8'h00, 8'h02, 32'h00000000, 1'b0);
    xact(1, 8'h64, 32'hffff0001, 30);
    $display("t_stall done");
  endtask
  task automatic t_bad();
    mk(MA, 8'h0a, 8'h01, 8'h00, 32'h7f7f7f7f, 1'b1);
    xact(0, 8'h01, 32'h00000000, 0);
    $display("t_bad done");
  endtask
  task automatic t_foreign();
    mk(8'h06, 8'h01, 8'h00, 8'h00, 32'h00000010, 1'b0);
    xact(0, 8'h00, 32'h00000000, 0);
    $display("t_foreign done");
  endtask
  task automatic t_idle();
    fr = {MA, 8'h01, 8'h02, 8'h03};
    host.send(fr);
    repeat (25) @(posedge clock_i);
    rsp_i <= '{8'h64, 32'h00000042};
    mk(MA, 8'h04, 8'h01, 8'h00, 32'hfff00000, 1'b0);
    xact(1, 8'h64, 32'h00000042, 0);
    $display("t_idle done");
  endtask
  task automatic t_can();
    can_mode_i <= 1'b1;
    @(posedge clock_i);
    rsp_i <= '{8'h64, 32'h0badcafe};
    mk(MA, 8'h0f, 8'h03, 8'h00, 32'h80000001, 1'b0);
    xact(1, 8'h64, 32'h0badcafe, 0);
    $display("t_can done");
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Main sequence: reset for six cycles, then every scenario in turn.
  initial begin
    repeat (6) @(posedge clock_i);
    `CHK(tx_oe_n_o, 1'b1)
    `CHK(exec_req_o, 1'b0)
    rst_i <= 1'b0;
    t_ok();
    t_codes();
    t_stall();
    t_bad();
    t_foreign();
    t_idle();
    t_can();
    final_report();
  end
  // Watchdog well beyond the expected run length.
  initial begin
    repeat (20000) @(posedge clock_i);
    errors++;
    $display("mismatch at %0t: watchdog expired", $time);
    final_report();
  end
endmodule
